// *** hdl/msss_pkg.sv ***
/*
  package of the multi-step speed sequencer: register map, field layouts,
  program modes, states and time base.
  assumes a 125 MHz clock and a 32-bit axi4-lite register bus.
*/
package msss_pkg;

  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TENTH_SEC_NS = 100_000_000;
  localparam int unsigned SEC_PER_MIN = 60;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MAX_FREQ = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SAVED = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STEP_BASE = 8'h40;
  localparam int unsigned STEP_CNT = 16;
  localparam int unsigned STEP_W = 4;
  localparam logic [15:0] MAX_FREQ_RST = 16'h1388;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // program modes and limits
  // ----------------------------------------
  localparam logic [1:0] MODE_ONCE_STOP = 2'h0;
  localparam logic [1:0] MODE_ONCE_HOLD = 2'h1;
  localparam logic [1:0] MODE_CYCLIC = 2'h2;
  localparam logic signed [15:0] SPEED_MAX = 16'sh0bb8;
  localparam logic signed [15:0] SPEED_MIN = -16'sh0bb8;
  localparam int signed SPEED_FULL = 1000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] run_time;
    logic signed [15:0] speed;
  } msss_step_type;

  typedef struct packed {
    logic plc_en;
    logic unit_min;
    logic retain;
    logic [1:0] mode;
  } msss_ctrl_type;

  typedef struct packed {
    logic [3:0] sel_step;
    logic [3:0] prog_step;
    logic hold;
    logic running;
    logic reverse;
    logic drive_run;
    logic saved_valid;
  } msss_status_type;

  typedef struct packed {
    logic valid;
    logic [3:0] step;
    logic signed [19:0] freq;
  } msss_saved_type;

  typedef enum logic [1:0] {
    MSSS_IDLE,
    MSSS_RUN,
    MSSS_HOLD
  } msss_state_type;

endpackage : msss_pkg

// *** hdl/msss_sequencer.sv ***
/*
  multi-step speed sequencer: sixteen signed speed steps with running times,
  run as a timed program or picked by four selection terminals; axi4-lite slave.
  assumes terminals and run command synchronous to clk; power_down warns of
  supply loss while the retained copy is kept by an always-on supply.
*/
// Our own choices: the AXI4-Lite register port and the address map.
// Contract
// - Mode 0 runs every step once, then stops the drive until a fresh run command.
// - Mode 1 keeps the last step's frequency and direction after one pass.
// - Mode 2 restarts from step 0 after each pass until the run command drops.
// - With retention on, step and frequency are saved at power loss and resumed.
// - Step speed is a signed per-mille value clamped to +-300.0 percent of max frequency.
// - Step time is held in tenths, counted in seconds or minutes by a unit select.
// - A negative step speed runs the motor in reverse.
// - Each program step outputs its own speed for its own time, then advances.
// - Fifteen steps, 1 to 15, are selectable by the four selection terminals.
// - Each nonzero terminal combination maps one-to-one onto steps 1 to 15.
// - With all terminals off the normal frequency source is used while the sequencer is idle.
// - Any active terminal makes the selected step override every other reference.
// - Start and stop follow the run-command channel, not the terminals.
`timescale 1ns/10ps
`default_nettype none
module msss_sequencer
  import msss_pkg::*;
#(
  parameter int unsigned TENTH_SEC_CYC = TENTH_SEC_NS / CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic run_cmd,
  input wire logic power_down,
  input wire logic step_select_bit0,
  input wire logic step_select_bit1,
  input wire logic step_select_bit2,
  input wire logic step_select_bit3,
  input wire logic signed [19:0] normal_freq_ref,
  output logic signed [19:0] freq_ref,
  output logic reverse,
  output logic drive_run
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic signed [19:0] scale(input logic signed [15:0] spd,
                                               input logic [15:0] maxf);
    logic signed [33:0] p;
    p = 34'(spd) * $signed({18'h0, maxf});
    return 20'(p / SPEED_FULL);
  endfunction : scale

  function automatic logic signed [15:0] clamp(input logic signed [15:0] spd);
    logic signed [15:0] r;
    r = spd;
    if (spd > SPEED_MAX) begin
      r = SPEED_MAX;
    end else if (spd < SPEED_MIN) begin
      r = SPEED_MIN;
    end
    return r;
  endfunction : clamp

  function automatic logic is_step(input logic [ADDR_W-1:0] a);
    return a >= OFS_STEP_BASE && a < OFS_STEP_BASE + ADDR_W'(STEP_CNT * 4);
  endfunction : is_step

  function automatic logic [STEP_W-1:0] step_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_STEP_BASE;
    return d[STEP_W+1:2];
  endfunction : step_idx

  // ----------------------------------------
  // state
  // ----------------------------------------
  msss_step_type step_q [STEP_CNT];
  msss_ctrl_type ctrl_q;
  msss_saved_type saved_q;
  msss_state_type state_q;
  logic [15:0] max_freq_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic aw_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_full_q;
  logic [STEP_W-1:0] sel_q;
  logic [STEP_W-1:0] prog_q;
  logic [15:0] remain_q;
  logic [31:0] div_q;
  logic [5:0] min_q;
  logic run_prev_q;
  logic stopped_q;
  logic tick;
  logic wr_do;
  logic run_rise;
  logic run_fall;
  logic last_step;
  logic signed [15:0] act_speed;
  msss_status_type status;
  localparam int unsigned CTRL_W = $bits(msss_ctrl_type);

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign awready = ~aw_full_q;
  assign wready = ~w_full_q;
  assign wr_do = aw_full_q & w_full_q & ~bvalid;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_do) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_do) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp <= (aw_addr_q == OFS_CTRL || aw_addr_q == OFS_MAX_FREQ || is_step(aw_addr_q))
               ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= '0;
      max_freq_q <= MAX_FREQ_RST;
    end else if (wr_do && aw_addr_q == OFS_CTRL) begin
      ctrl_q <= msss_ctrl_type'(CTRL_W'(merge(32'(ctrl_q), w_data_q, w_strb_q)));
    end else if (wr_do && aw_addr_q == OFS_MAX_FREQ) begin
      max_freq_q <= 16'(merge({16'h0, max_freq_q}, w_data_q, w_strb_q));
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STEP_CNT; i++) begin
        step_q[i] <= '0;
      end
    end else if (wr_do && is_step(aw_addr_q)) begin
      step_q[step_idx(aw_addr_q)] <= merge(step_q[step_idx(aw_addr_q)], w_data_q, w_strb_q);
      step_q[step_idx(aw_addr_q)].speed <=
        clamp(16'(merge(step_q[step_idx(aw_addr_q)], w_data_q, w_strb_q)));
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  assign arready = ~rvalid;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      if (araddr == OFS_CTRL) begin
        rdata <= 32'(ctrl_q);
      end else if (araddr == OFS_STATUS) begin
        rdata <= 32'(status);
      end else if (araddr == OFS_MAX_FREQ) begin
        rdata <= {16'h0, max_freq_q};
      end else if (araddr == OFS_SAVED) begin
        rdata <= 32'(saved_q);
      end else if (is_step(araddr)) begin
        rdata <= step_q[step_idx(araddr)];
      end else begin
        rdata <= '0;
        rresp <= RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // time base
  // ----------------------------------------
  // tenth-second or tenth-minute tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= '0;
      min_q <= '0;
    end else if (state_q != MSSS_RUN) begin
      div_q <= '0;
      min_q <= '0;
    end else if (div_q == 32'(TENTH_SEC_CYC - 1)) begin
      div_q <= '0;
      min_q <= (min_q == 6'(SEC_PER_MIN - 1)) ? '0 : min_q + 6'h01;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  assign tick = (div_q == 32'(TENTH_SEC_CYC - 1)) &&
                (!ctrl_q.unit_min || min_q == 6'(SEC_PER_MIN - 1));

  // ----------------------------------------
  // program sequencer
  // ----------------------------------------
  assign run_rise = run_cmd & ~run_prev_q;
  assign run_fall = ~run_cmd & run_prev_q;
  assign last_step = (prog_q == STEP_W'(STEP_CNT - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run_cmd;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= MSSS_IDLE;
      prog_q <= '0;
      remain_q <= '0;
      stopped_q <= 1'b0;
    end else if (power_down) begin
      state_q <= MSSS_IDLE;
    end else begin
      case (state_q)
        MSSS_IDLE: begin
          if (run_rise) begin
            stopped_q <= 1'b0;
            if (ctrl_q.plc_en) begin
              state_q <= MSSS_RUN;
              prog_q <= (ctrl_q.retain && saved_q.valid) ? saved_q.step : '0;
              remain_q <= step_q[(ctrl_q.retain && saved_q.valid) ? saved_q.step : '0].run_time;
            end
          end
        end
        MSSS_RUN: begin
          if (run_fall) begin
            state_q <= MSSS_IDLE;
          end else if (remain_q == 16'h0) begin
            if (!last_step) begin
              prog_q <= prog_q + STEP_W'(1);
              remain_q <= step_q[prog_q + STEP_W'(1)].run_time;
            end else if (ctrl_q.mode == MODE_ONCE_HOLD) begin
              state_q <= MSSS_HOLD;
            end else if (ctrl_q.mode == MODE_CYCLIC) begin
              prog_q <= '0;
              remain_q <= step_q[0].run_time;
            end else begin
              state_q <= MSSS_IDLE;
              stopped_q <= 1'b1;
            end
          end else if (tick) begin
            remain_q <= remain_q - 16'h1;
          end
        end
        MSSS_HOLD: begin
          if (run_fall) begin
            state_q <= MSSS_IDLE;
          end
        end
        default: begin
          state_q <= MSSS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      saved_q <= '0;
    end else if (power_down && state_q != MSSS_IDLE) begin
      saved_q <= '{valid: 1'b1, step: prog_q, freq: freq_ref};
    end else if (run_rise && !ctrl_q.retain) begin
      saved_q <= '0;
    end
  end

  // ----------------------------------------
  // reference selection
  // ----------------------------------------
  // terminal code, bit0 lsb
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= '0;
    end else begin
      sel_q <= {step_select_bit3, step_select_bit2, step_select_bit1, step_select_bit0};
    end
  end

  assign act_speed = (sel_q != '0) ? step_q[sel_q].speed : step_q[prog_q].speed;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_ref <= '0;
      reverse <= 1'b0;
      drive_run <= 1'b0;
    end else begin
      drive_run <= run_cmd & ~stopped_q & ~power_down;
      if (sel_q != '0 || state_q != MSSS_IDLE) begin
        freq_ref <= scale(act_speed, max_freq_q);
        reverse <= act_speed < 0;
      end else begin
        freq_ref <= normal_freq_ref;
        reverse <= normal_freq_ref < 0;
      end
    end
  end

  assign status = '{sel_step: sel_q, prog_step: prog_q, hold: state_q == MSSS_HOLD,
                    running: state_q == MSSS_RUN, reverse: reverse, drive_run: drive_run,
                    saved_valid: saved_q.valid};

endmodule : msss_sequencer
`default_nettype wire

// *** verification/msss_checker.sv ***
/*
  port checker of the multi-step speed sequencer.
  assumes it is bound to msss_sequencer and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module msss_checker
  import msss_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic arready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic run_cmd,
  input wire logic power_down,
  input wire logic step_select_bit0,
  input wire logic step_select_bit1,
  input wire logic step_select_bit2,
  input wire logic step_select_bit3,
  input wire logic signed [19:0] normal_freq_ref,
  input wire logic signed [19:0] freq_ref,
  input wire logic reverse,
  input wire logic drive_run
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  wire logic sel_off = !(step_select_bit0 | step_select_bit1 | step_select_bit2
                         | step_select_bit3);

  // ---
  // assertions
  // ---
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_done: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read response not retired");
  a_neg_reverse: assert property (freq_ref < 0 |-> reverse)
    else $error("negative reference runs forward");
  a_pos_forward: assert property (freq_ref > 0 |-> !reverse)
    else $error("positive reference runs reverse");
  a_power_stop: assert property (power_down |=> !drive_run)
    else $error("drive kept running at power loss");
  a_drop_stops: assert property ($fell(run_cmd) |-> ##[1:2] !drive_run)
    else $error("drive kept running after stop");
  a_start_cmd: assert property ($rose(drive_run) |-> run_cmd)
    else $error("drive started without run command");
  a_normal_src: assert property ((sel_off && !drive_run && !run_cmd && !power_down
      && $stable(normal_freq_ref))[*4] |-> freq_ref == normal_freq_ref)
    else $error("normal reference not passed");

  c_run: cover property ($rose(drive_run));
  c_rev: cover property (drive_run && reverse);
  c_err: cover property (bvalid && bresp == RESP_SLVERR);
endmodule : msss_checker
`default_nettype wire

// *** verification/msss_cmd_source.sv ***
/*
  run command channel, supply warning and selection terminals of the drive.
  assumes the bench calls put right after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module msss_cmd_source (
  input wire logic clk,
  output logic run_cmd,
  output logic power_down,
  output logic [3:0] sel
);
  initial begin
    run_cmd = 1'b0;
    power_down = 1'b0;
    sel = 4'h0;
  end

  task automatic put(input logic r, input logic [3:0] s, input logic p);
    @(posedge clk);
    run_cmd <= r;
    sel <= s;
    power_down <= p;
  endtask : put
endmodule : msss_cmd_source
`default_nettype wire

// *** verification/msss_sequencer_tb.sv ***
/*
  bench of the multi-step speed sequencer: axi4-lite master, step model.
  assumes msss_pkg, msss_checker and msss_cmd_source compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
bind msss_sequencer msss_checker chk (.clk(clk), .rst_b(rst_b), .arready(arready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .run_cmd(run_cmd), .power_down(power_down),
  .step_select_bit0(step_select_bit0), .step_select_bit1(step_select_bit1),
  .step_select_bit2(step_select_bit2), .step_select_bit3(step_select_bit3),
  .normal_freq_ref(normal_freq_ref), .freq_ref(freq_ref), .reverse(reverse),
  .drive_run(drive_run));
module msss_sequencer_tb
  import msss_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, q;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic signed [19:0] nfr = 20'sh0;
  logic [31:0] seed = 32'h50119ad1;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, reverse, drive_run, run_cmd, power_down;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] sel;
  wire signed [19:0] freq_ref;
  int spd[16];
  localparam int TSC = 4;
  int mf = int'(MAX_FREQ_RST);
  int fail_count = 0;
  int tests_run = 0;

  msss_sequencer #(.TENTH_SEC_CYC(TSC)) DUT (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .run_cmd(run_cmd), .power_down(power_down),
    .step_select_bit0(sel[0]), .step_select_bit1(sel[1]), .step_select_bit2(sel[2]),
    .step_select_bit3(sel[3]), .normal_freq_ref(nfr), .freq_ref(freq_ref),
    .reverse(reverse), .drive_run(drive_run));
  msss_cmd_source src (.clk(clk), .run_cmd(run_cmd), .power_down(power_down), .sel(sel));

  always #4 clk = ~clk;

  // ---
  // model and checks
  // ---
  function automatic logic [31:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : nxt

  function automatic int fx(input int k);
    return spd[k] * mf / SPEED_FULL;
  endfunction : fx

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_freq(input int e);
    chk_word({reverse, 11'h0, freq_ref}, {e < 0, 11'h0, e[19:0]});
  endtask : chk_freq

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    int n;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(w ? bvalid : rvalid) && n < 99);
    rd = rdata;
    rs = w ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
    if (n >= 99) fail_count++;
  endtask : bus

  task automatic set_step(input int k, input logic signed [15:0] s, input logic [15:0] t);
    int v;
    v = s > SPEED_MAX ? SPEED_MAX : s < SPEED_MIN ? SPEED_MIN : s;
    spd[k] = v;
    bus(1'b1, OFS_STEP_BASE + 8'(4 * k), {t, s}, q, r);
    chk_word(32'(r), 32'(RESP_OKAY));
    bus(1'b0, OFS_STEP_BASE + 8'(4 * k), 32'h0, q, r);
    chk_word(32'(r), 32'(RESP_OKAY));
    chk_word(q, {t, v[15:0]});
  endtask : set_step

  task automatic prog(input logic [3:0] c, input int first, input int n);
    int k;
    int w;
    logic signed [19:0] last;
    bus(1'b1, OFS_CTRL, {28'h1, c}, q, r);
    src.put(1'b1, 4'h0, 1'b0);
    last = 20'sh0;
    k = 0;
    w = 0;
    while (k < n && w < 3000) begin
      @(posedge clk);
      w++;
      if (drive_run === 1'b1 && freq_ref !== last) begin
        chk_freq(fx((first + k) % 16));
        last = freq_ref;
        k++;
      end
    end
    if (w >= 3000) fail_count++;
  endtask : prog

  // ---
  // tests
  // ---
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, OFS_MAX_FREQ, 32'h0, q, r);
    chk_word(q, 32'h1388);
    bus(1'b0, 8'h10, 32'h0, q, r);
    chk_word({q[29:0], r}, {30'h0, RESP_SLVERR});
    bus(1'b1, 8'h10, 32'h0, q, r);
    chk_word(32'(r), 32'(RESP_SLVERR));
    wstrb <= 4'h1;
    bus(1'b1, OFS_MAX_FREQ, 32'hffff_0fa0, q, r);
    chk_word(32'(r), 32'(RESP_OKAY));
    wstrb <= 4'hf;
    // only byte 0 written: the upper byte keeps its reset value
    mf = int'({MAX_FREQ_RST[15:8], 8'ha0});
    bus(1'b0, OFS_MAX_FREQ, 32'h0, q, r);
    chk_word(q, 32'(mf));
    $display("reset and map done");
    for (int k = 0; k < 16; k++) set_step(k, 16'(nxt()), 16'h2);
    // alternate signs so that neighbouring steps never share a reference
    for (int k = 0; k < 16; k++) begin
      set_step(k, 16'((k % 2 ? -1 : 1) * (int'(nxt() % 2900) + 50)), 16'h2);
    end
    $display("step table done");
    nfr <= 20'(nxt());
    for (int k = 1; k < 16; k++) begin
      src.put(1'b0, 4'(k), 1'b0);
      repeat (4) @(posedge clk);
      chk_freq(fx(k));
    end
    src.put(1'b0, 4'h0, 1'b0);
    repeat (4) @(posedge clk);
    chk_freq(nfr);
    $display("terminal select done");
    nfr <= 20'sh0;
    prog(4'h0, 0, 16);
    repeat (30) @(posedge clk);
    chk_word(32'(drive_run), 32'h0);
    src.put(1'b0, 4'h0, 1'b0);
    $display("once-stop done");
    prog(4'h1, 0, 16);
    repeat (30) @(posedge clk);
    chk_freq(fx(15));
    chk_word(32'(drive_run), 32'h1);
    src.put(1'b0, 4'h0, 1'b0);
    repeat (3) @(posedge clk);
    chk_word(32'(drive_run), 32'h0);
    $display("once-hold done");
    // minute unit: two ticks of a tenth minute per step, 480 cycles each step
    bus(1'b1, OFS_CTRL, 32'h18, q, r);
    src.put(1'b1, 4'h0, 1'b0);
    repeat (SEC_PER_MIN * TSC * 2 - 80) @(posedge clk);
    chk_freq(fx(0));
    src.put(1'b1, 4'h3, 1'b0);
    repeat (4) @(posedge clk);
    chk_freq(fx(3));
    src.put(1'b1, 4'h0, 1'b0);
    repeat (190) @(posedge clk);
    chk_freq(fx(1));
    src.put(1'b0, 4'h0, 1'b0);
    $display("minute unit done");
    prog(4'h6, 0, 22);
    src.put(1'b1, 4'h0, 1'b1);
    repeat (2) @(posedge clk);
    chk_word(32'(drive_run), 32'h0);
    bus(1'b0, OFS_SAVED, 32'h0, q, r);
    chk_word(q, {7'h0, 1'b1, 4'h5, 20'(fx(5))});
    bus(1'b0, OFS_STATUS, 32'h0, q, r);
    chk_word(q, {19'h0, 4'h0, 4'h5, 5'b00001});
    src.put(1'b0, 4'h0, 1'b1);
    src.put(1'b0, 4'h0, 1'b0);
    prog(4'h6, 5, 3);
    src.put(1'b0, 4'h0, 1'b0);
    $display("cyclic and retention done");
    wrap_up();
  end

  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule : msss_sequencer_tb
`default_nettype wire
